// [verilog/blt_defs.svh]
`ifndef BLT_DEFS_SVH
`define BLT_DEFS_SVH

// register indices, byte address is four times the index
`define BLT_IDX_START 16'h1800
`define BLT_IDX_SRST 16'h1802
`define BLT_IDX_FMT 16'h1804
`define BLT_IDX_IRQ_STAT 16'h1b00
`define BLT_IDX_IRQ_CLR 16'h1b02
`define BLT_IDX_IRQ_EN 16'h1b04

// widths
`define BLT_ADDR_W 16
`define BLT_DATA_W 32
`define BLT_STRB_W 4
`define BLT_REG_W 16
`define BLT_OP_W 3
`define BLT_BPP_W 6
`define BLT_IRQ_W 3

// field positions
`define BLT_START_BIT 0
`define BLT_SRST_BIT 0
`define BLT_SRC_MODE_BIT 0
`define BLT_DST_MODE_BIT 1
`define BLT_FMT_LSB 2
`define BLT_FMT_MSB 3
`define BLT_IRQ_DONE 0
`define BLT_IRQ_SRST 1
`define BLT_IRQ_FMT 2

// reset values
`define BLT_FMT_REG_RESET 4'h0
`define BLT_IRQ_RESET 3'h0

// engine operation codes
`define BLT_OP_MOVE 3'h2
`define BLT_OP_PFILL 3'h4

// pixel depths
`define BLT_BPP_8 6'h08
`define BLT_BPP_16 6'h10
`define BLT_BPP_32 6'h20
`define BLT_BPP_NONE 6'h00

// bus responses
`define BLT_RESP_OKAY 2'h0
`define BLT_RESP_SLVERR 2'h2

// timing
`define BLT_CLK_PERIOD_NS 100
`define BLT_SRST_TIME_NS 200
`define BLT_SRST_CYCLES \
  ((`BLT_SRST_TIME_NS + `BLT_CLK_PERIOD_NS - 1) / `BLT_CLK_PERIOD_NS)

`endif

// [verilog/blt_pkg.sv]
package blt_pkg;

  typedef enum logic [1:0] {
    BLT_IDLE = 2'b00,
    BLT_BUSY = 2'b01,
    BLT_SRST = 2'b10
  } blt_state_e;

  typedef enum logic [1:0] {
    BLT_FMT_8 = 2'b00,
    BLT_FMT_16 = 2'b01,
    BLT_FMT_32 = 2'b10,
    BLT_FMT_RSV = 2'b11
  } blt_fmt_e;

endpackage

// [verilog/blt_timer.sv]
`timescale 1ns/10ps
module blt_timer #(
  parameter int CYCLES = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic active_o,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  generate
    if (CYCLES < 1) begin : g_chk
      $error("blt_timer: CYCLES must be at least 1");
    end
  endgenerate

  // countdown, restart on every start
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= CW'(CYCLES);
    end else if (count != '0) begin
      count <= count - CW'(1);
    end
  end

  assign active_o = (count != '0);
  assign done_o = (count == CW'(1)) && !start_i;

endmodule // blt_timer

// [verilog/blt_ctrl.sv]
// Overview of operation
// RL1 - start bit launches blit on one, ignores zero, reads busy, self-clears
// RL2 - writing one to reset bit resets engine and blit registers to defaults
// RL3 - reset bit is write-only; its register reads back no stored state
// RL4 - reset bit returns to zero by itself when engine reset finishes
// RL5 - writing zero to reset bit disturbs neither engine nor registers
// RL6 - colour format bits 3:2: 00 eight, 01 sixteen, 10 thirty-two bpp
// RL7 - software must not program reserved colour format code 11
// RL8 - destination mode: 0 rectangular, 1 linear; ignored for pattern fill
// RL9 - source mode: 0 rectangular, 1 linear; used only for move operations
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "blt_defs.svh"
module blt_ctrl #(
  parameter int SRST_CYCLES = `BLT_SRST_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [`BLT_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [`BLT_DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [`BLT_STRB_W-1:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [`BLT_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [`BLT_DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [`BLT_OP_W-1:0] BLT_OP_I,
  input wire logic BLT_DONE_I,
  output logic BLT_START_O,
  output logic BLT_BUSY_O,
  output logic BLT_ENG_RST_O,
  output logic BLT_REGS_RST_O,
  output logic [1:0] BLT_FMT_O,
  output logic [`BLT_BPP_W-1:0] BLT_BPP_O,
  output logic BLT_SRC_LINEAR_O,
  output logic BLT_DST_LINEAR_O,
  output logic IRQ_O
);
  generate
    if (SRST_CYCLES < 1) begin : g_chk
      $error("blt_ctrl: SRST_CYCLES must be at least 1");
    end
  endgenerate
  function automatic logic [`BLT_ADDR_W-1:0] byte_addr(
    input logic [`BLT_ADDR_W-1:0] idx
  );
    byte_addr = {idx[`BLT_ADDR_W-3:0], 2'h0};
  endfunction
  function automatic logic mapped(input logic [`BLT_ADDR_W-1:0] a);
    mapped = (a == byte_addr(`BLT_IDX_START)) ||
             (a == byte_addr(`BLT_IDX_SRST)) ||
             (a == byte_addr(`BLT_IDX_FMT)) ||
             (a == byte_addr(`BLT_IDX_IRQ_STAT)) ||
             (a == byte_addr(`BLT_IDX_IRQ_CLR)) ||
             (a == byte_addr(`BLT_IDX_IRQ_EN));
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // write channel capture
  logic aw_full;
  logic [`BLT_ADDR_W-1:0] aw_addr;
  logic w_full;
  logic [`BLT_DATA_W-1:0] w_data;
  logic [`BLT_STRB_W-1:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic wr_go;
  assign S_AXI_AWREADY_O = !aw_full && !bvalid;
  assign S_AXI_WREADY_O = !w_full && !bvalid;
  assign wr_go = aw_full && w_full && !bvalid;
  assign S_AXI_BVALID_O = bvalid;
  assign S_AXI_BRESP_O = bresp;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      bvalid <= 1'b0;
      bresp <= `BLT_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr) ? `BLT_RESP_OKAY : `BLT_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // write decode
  logic lane0;
  logic start_req;
  logic srst_req;
  logic fmt_wr;
  logic en_wr;
  logic [`BLT_IRQ_W-1:0] irq_clr;
  assign lane0 = w_strb[0];
  // RL1 start on one
  assign start_req = wr_go && lane0 &&
                     (aw_addr == byte_addr(`BLT_IDX_START)) &&
                     w_data[`BLT_START_BIT];
  // RL5 zero ignored
  assign srst_req = wr_go && lane0 &&
                    (aw_addr == byte_addr(`BLT_IDX_SRST)) &&
                    w_data[`BLT_SRST_BIT];
  assign fmt_wr = wr_go && lane0 && (aw_addr == byte_addr(`BLT_IDX_FMT));
  assign en_wr = wr_go && lane0 &&
                 (aw_addr == byte_addr(`BLT_IDX_IRQ_EN));
  assign irq_clr = (wr_go && lane0 &&
                    (aw_addr == byte_addr(`BLT_IDX_IRQ_CLR))) ?
                   w_data[`BLT_IRQ_W-1:0] : '0;
  //////////////////////////////////////////////////////////////////////////
  // engine sequencing
  blt_pkg::blt_state_e state;
  blt_pkg::blt_state_e next_state;
  logic srst_active;
  logic srst_done;
  logic [3:0] fmt_reg;
  logic fmt_rsv;
  assign fmt_rsv = (fmt_reg[`BLT_FMT_MSB:`BLT_FMT_LSB] ==
                    blt_pkg::BLT_FMT_RSV);
  // RL4 reset duration
  blt_timer #(
    .CYCLES(SRST_CYCLES)
  ) u_srst_timer (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .start_i(srst_req),
    .active_o(srst_active),
    .done_o(srst_done)
  );
  always_comb begin
    next_state = state;
    case (state)
      blt_pkg::BLT_IDLE: begin
        if (srst_req) begin
          next_state = blt_pkg::BLT_SRST;
        end else if (start_req) begin
          next_state = blt_pkg::BLT_BUSY;
        end
      end
      blt_pkg::BLT_BUSY: begin
        // RL2 reset aborts blit
        if (srst_req) begin
          next_state = blt_pkg::BLT_SRST;
        // RL1 self-clearing
        end else if (BLT_DONE_I) begin
          next_state = blt_pkg::BLT_IDLE;
        end
      end
      blt_pkg::BLT_SRST: begin
        // RL4 auto return
        if (srst_done) begin
          next_state = blt_pkg::BLT_IDLE;
        end
      end
      default: begin
        next_state = blt_pkg::BLT_IDLE;
      end
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state <= blt_pkg::BLT_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // RL1 launch pulse
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      BLT_START_O <= 1'b0;
    end else begin
      BLT_START_O <= (state == blt_pkg::BLT_IDLE) && start_req &&
                     !srst_req;
    end
  end
  // RL2 engine and register reset
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      BLT_ENG_RST_O <= 1'b0;
      BLT_REGS_RST_O <= 1'b0;
    end else begin
      BLT_ENG_RST_O <= srst_req || srst_active;
      BLT_REGS_RST_O <= srst_req;
    end
  end
  assign BLT_BUSY_O = (state == blt_pkg::BLT_BUSY);
  //////////////////////////////////////////////////////////////////////////
  // format and layout register
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      fmt_reg <= `BLT_FMT_REG_RESET;
    // RL2 restore default
    end else if (srst_req) begin
      fmt_reg <= `BLT_FMT_REG_RESET;
    end else if (fmt_wr) begin
      fmt_reg <= w_data[3:0];
    end
  end
  // RL6 pixel depth
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      BLT_BPP_O <= `BLT_BPP_8;
      BLT_FMT_O <= 2'h0;
    end else begin
      BLT_FMT_O <= fmt_reg[`BLT_FMT_MSB:`BLT_FMT_LSB];
      case (fmt_reg[`BLT_FMT_MSB:`BLT_FMT_LSB])
        blt_pkg::BLT_FMT_8: begin
          BLT_BPP_O <= `BLT_BPP_8;
        end
        blt_pkg::BLT_FMT_16: begin
          BLT_BPP_O <= `BLT_BPP_16;
        end
        blt_pkg::BLT_FMT_32: begin
          BLT_BPP_O <= `BLT_BPP_32;
        end
        default: begin
          BLT_BPP_O <= `BLT_BPP_NONE;
        end
      endcase
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      BLT_SRC_LINEAR_O <= 1'b0;
      BLT_DST_LINEAR_O <= 1'b0;
    end else begin
      // RL9 source for move only
      BLT_SRC_LINEAR_O <= fmt_reg[`BLT_SRC_MODE_BIT] &&
                          (BLT_OP_I == `BLT_OP_MOVE);
      // RL8 dest ignored on fill
      BLT_DST_LINEAR_O <= fmt_reg[`BLT_DST_MODE_BIT] &&
                          (BLT_OP_I != `BLT_OP_PFILL);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [`BLT_IRQ_W-1:0] irq_stat;
  logic [`BLT_IRQ_W-1:0] irq_en;
  logic [`BLT_IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = '0;
    irq_evt[`BLT_IRQ_DONE] = (state == blt_pkg::BLT_BUSY) && BLT_DONE_I &&
                             !srst_req;
    irq_evt[`BLT_IRQ_SRST] = srst_done;
    irq_evt[`BLT_IRQ_FMT] = (state == blt_pkg::BLT_IDLE) && start_req &&
                            !srst_req && fmt_rsv;
  end
  // set wins over clear
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      irq_stat <= `BLT_IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      irq_en <= `BLT_IRQ_RESET;
    end else if (en_wr) begin
      irq_en <= w_data[`BLT_IRQ_W-1:0];
    end
  end
  assign IRQ_O = |(irq_stat & irq_en);
  //////////////////////////////////////////////////////////////////////////
  // read channel
  logic rvalid;
  logic [`BLT_DATA_W-1:0] rdata;
  logic [1:0] rresp;
  assign S_AXI_ARREADY_O = !rvalid;
  assign S_AXI_RVALID_O = rvalid;
  assign S_AXI_RDATA_O = rdata;
  assign S_AXI_RRESP_O = rresp;
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `BLT_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && !rvalid) begin
      rvalid <= 1'b1;
      rresp <= `BLT_RESP_OKAY;
      rdata <= '0;
      // RL1 busy readback
      if (S_AXI_ARADDR_I == byte_addr(`BLT_IDX_START)) begin
        rdata[`BLT_START_BIT] <= (state == blt_pkg::BLT_BUSY);
      // RL3 write-only reads zero
      end else if ((S_AXI_ARADDR_I == byte_addr(`BLT_IDX_SRST)) ||
                   (S_AXI_ARADDR_I == byte_addr(`BLT_IDX_IRQ_CLR))) begin
        rdata <= '0;
      end else if (S_AXI_ARADDR_I == byte_addr(`BLT_IDX_FMT)) begin
        rdata[3:0] <= fmt_reg;
      end else if (S_AXI_ARADDR_I == byte_addr(`BLT_IDX_IRQ_STAT)) begin
        rdata[`BLT_IRQ_W-1:0] <= irq_stat;
      end else if (S_AXI_ARADDR_I == byte_addr(`BLT_IDX_IRQ_EN)) begin
        rdata[`BLT_IRQ_W-1:0] <= irq_en;
      end else begin
        rresp <= `BLT_RESP_SLVERR;
      end
    end else if (S_AXI_RREADY_I) begin
      rvalid <= 1'b0;
    end
  end

endmodule // blt_ctrl

// [test/blt_ctrl_sva.sv]
`timescale 1ns/10ps
module blt_ctrl_chk #(
  parameter int SRST_CYCLES = 2
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] BLT_OP_I,
  input wire logic BLT_DONE_I,
  input wire logic BLT_START_O,
  input wire logic BLT_BUSY_O,
  input wire logic BLT_ENG_RST_O,
  input wire logic BLT_REGS_RST_O,
  input wire logic [1:0] BLT_FMT_O,
  input wire logic [5:0] BLT_BPP_O,
  input wire logic BLT_SRC_LINEAR_O,
  input wire logic BLT_DST_LINEAR_O
);
  int rst_len;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////
  // length of the engine reset
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I || !BLT_ENG_RST_O) rst_len <= 0;
    else rst_len <= rst_len + 1;
  end
  ////////////////////////////////////////
  a_start_one_pulse: assert property (
    BLT_START_O |=> !BLT_START_O) else $error("start pulse too long");
  a_start_with_busy: assert property (
    BLT_START_O |-> BLT_BUSY_O) else $error("start without busy");
  a_done_clears_busy: assert property (
    BLT_BUSY_O && BLT_DONE_I |=> !BLT_BUSY_O) else $error("busy stuck");
  a_eng_rst_len: assert property (
    $fell(BLT_ENG_RST_O) |-> rst_len == SRST_CYCLES + 1)
    else $error("engine reset length wrong");
  a_regs_rst_pulse: assert property (
    $rose(BLT_ENG_RST_O) |-> BLT_REGS_RST_O ##1 !BLT_REGS_RST_O)
    else $error("register reset pulse wrong");
  a_srst_no_busy: assert property (
    $rose(BLT_ENG_RST_O) |-> !BLT_BUSY_O) else $error("busy kept");
  a_srst_fmt_clear: assert property (
    BLT_REGS_RST_O |=> BLT_FMT_O == 2'h0) else $error("format kept");
  a_bpp_map: assert property (
    BLT_BPP_O == (BLT_FMT_O == 2'h0 ? 6'h08 : BLT_FMT_O == 2'h1 ? 6'h10 :
    BLT_FMT_O == 2'h2 ? 6'h20 : 6'h00)) else $error("pixel depth wrong");
  a_src_move_only: assert property (
    BLT_SRC_LINEAR_O |-> $past(BLT_OP_I) == 3'h2) else $error("src mode");
  a_dst_not_pfill: assert property (
    BLT_DST_LINEAR_O |-> $past(BLT_OP_I) != 3'h4) else $error("dst mode");
endmodule // blt_ctrl_chk

bind blt_ctrl blt_ctrl_chk #(.SRST_CYCLES(SRST_CYCLES)) u_chk (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .BLT_OP_I(BLT_OP_I),
  .BLT_DONE_I(BLT_DONE_I), .BLT_START_O(BLT_START_O),
  .BLT_BUSY_O(BLT_BUSY_O), .BLT_ENG_RST_O(BLT_ENG_RST_O),
  .BLT_REGS_RST_O(BLT_REGS_RST_O), .BLT_FMT_O(BLT_FMT_O),
  .BLT_BPP_O(BLT_BPP_O), .BLT_SRC_LINEAR_O(BLT_SRC_LINEAR_O),
  .BLT_DST_LINEAR_O(BLT_DST_LINEAR_O));

// [test/test_blit_engine_control.sv]
`timescale 1ns/10ps
module test_blit_engine_control;
  logic clk, rst_n, awv, wv, arv, done, awr, wrd, bv, arr, rv, start, busy;
  logic erst, rrst, sl, dl, irq;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat, v;
  logic [3:0] st;
  logic [2:0] op;
  logic [1:0] br, rr, fmt;
  logic [5:0] bpp;
  int miscompares = 0, n_checks = 0, starts = 0;
  blt_ctrl #(.SRST_CYCLES(2)) DUT (.MCLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(st), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .BLT_OP_I(op),
    .BLT_DONE_I(done), .BLT_START_O(start), .BLT_BUSY_O(busy),
    .BLT_ENG_RST_O(erst), .BLT_REGS_RST_O(rrst), .BLT_FMT_O(fmt),
    .BLT_BPP_O(bpp), .BLT_SRC_LINEAR_O(sl), .BLT_DST_LINEAR_O(dl),
    .IRQ_O(irq));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (start) starts++;
  function logic [5:0] bpp_of(input logic [1:0] f);
    return f == 2'h0 ? 6'h08 : f == 2'h1 ? 6'h10 : f == 2'h2 ? 6'h20 : 6'h00;
  endfunction
  task chk(input string s, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task final_report;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    chk("bresp", br, e);
  endtask
  task rchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk("rdata", rdat, e);
    chk("rresp", rr, r);
  endtask
  ////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    final_report;
  end
  initial begin
    void'($urandom(32'h3e9fbc66));
    rst_n = 0; awv = 0; wv = 0; arv = 0; done = 0; st = 4'hf; op = 0;
    awa = 0; ara = 0; wd = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk("bpp", bpp, 6'h08);
    rchk(16'h6000, 0, 0);
    rchk(16'h6010, 0, 0);
    wr(16'h6c10, 32'h7, 0);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v[3:2] = i[1:0];
      if (i < 2) v[1:0] = 2'h3;
      op <= i < 2 ? 3'(2 + 2 * i) : 3'($urandom);
      wr(16'h6010, v, 0);
      @(posedge clk);
      chk("fmt", fmt, v[3:2]);
      chk("bpp", bpp, bpp_of(v[3:2]));
      chk("src", sl, v[0] && op == 3'h2);
      chk("dst", dl, v[1] && op != 3'h4);
      rchk(16'h6010, {28'h0, v[3:0]}, 0);
    end
    wr(16'h6010, 32'h4, 0);
    wr(16'h6000, 32'h0, 0);
    chk("busy", busy, 0);
    wr(16'h6000, 32'h1, 0);
    chk("busy", busy, 1);
    wr(16'h6000, 32'h1, 0);
    rchk(16'h6000, 1, 0);
    chk("starts", starts, 1);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
    chk("busy", busy, 0);
    chk("irq", irq, 1);
    rchk(16'h6000, 0, 0);
    rchk(16'h6c00, 1, 0);
    wr(16'h6c08, 32'h1, 0);
    chk("irq", irq, 0);
    wr(16'h6010, 32'hb, 0);
    wr(16'h6000, 32'h1, 0);
    wr(16'h6008, 32'h0, 0);
    chk("busy", busy, 1);
    chk("fmt", fmt, 2);
    chk("erst", erst, 0);
    wr(16'h6008, 32'h1, 0);
    repeat (4) @(posedge clk);
    chk("erst", erst, 0);
    chk("busy", busy, 0);
    rchk(16'h6010, 0, 0);
    rchk(16'h6008, 0, 0);
    rchk(16'h6c00, 2, 0);
    chk("irq", irq, 1);
    wr(16'h6c10, 32'h0, 0);
    chk("irq", irq, 0);
    wr(16'h7000, 32'hf, 2);
    rchk(16'h7000, 0, 2);
    st <= 4'h0;
    wr(16'h6010, 32'h4, 0);
    rchk(16'h6010, 0, 0);
    st <= 4'hf;
    wr(16'h6010, 32'hc, 0);
    wr(16'h6000, 32'h1, 0);
    chk("busy", busy, 1);
    rchk(16'h6c00, 32'h6, 0);
    final_report;
  end
endmodule // test_blit_engine_control
